// ### logic/fspc_pkg.sv
// package: constants, register map and carrier types for fail-safe control
package fspc_pkg;
    // register byte offsets
    localparam logic [7:0] FSPC_OFF_CTRL   = 8'h00;
    localparam logic [7:0] FSPC_OFF_RELOAD = 8'h04;
    localparam logic [7:0] FSPC_OFF_POWER  = 8'h08;
    localparam logic [7:0] FSPC_OFF_STATUS = 8'h0C;
    localparam logic [7:0] FSPC_OFF_COUNT  = 8'h10;
    // control field positions
    localparam int FSPC_CTRL_REFRESH   = 0;
    localparam int FSPC_CTRL_START     = 1;
    localparam int FSPC_CTRL_RATE      = 2;
    localparam int FSPC_CTRL_CLR_FLAG  = 3;
    // power control bit values
    localparam logic [7:0] FSPC_PWR_IDLE_ARM = 8'h01;
    localparam logic [7:0] FSPC_PWR_PD_ARM   = 8'h02;
    localparam logic [7:0] FSPC_PWR_SLOW     = 8'h10;
    localparam logic [7:0] FSPC_PWR_IDLE_GO  = 8'h20;
    localparam logic [7:0] FSPC_PWR_PD_GO    = 8'h40;
    localparam logic [7:0] FSPC_PWR_SLOW_CLR = 8'hEF;
    // status bit positions
    localparam int FSPC_ST_WD_RESET = 0;
    localparam int FSPC_ST_RUNNING  = 1;
    localparam int FSPC_ST_IDLE     = 2;
    localparam int FSPC_ST_SWPD     = 3;
    localparam int FSPC_ST_HW_POWERDOWN_PIN     = 4;
    localparam int FSPC_ST_OSCRST   = 5;
    localparam int FSPC_ST_SLOW     = 6;
    // reset values
    localparam logic [6:0]  FSPC_RELOAD_RST = 7'h00;
    localparam logic [14:0] FSPC_COUNT_RST  = 15'h0000;
    // timing
    localparam int FSPC_CLK_MHZ     = 100;
    localparam int FSPC_DIV_FAST    = 12;
    localparam int FSPC_DIV_SLOW    = 384;
    localparam int FSPC_SLOW_DIV    = 8;
    localparam int FSPC_OSC_HOLD_US = 500;
    localparam int FSPC_OSC_HOLD_CYC = FSPC_OSC_HOLD_US * FSPC_CLK_MHZ;
    localparam int FSPC_WD_RST_CYC  = 4;

    typedef enum logic [1:0] {
        FSPC_OSC_OK    = 2'b00,
        FSPC_OSC_FAIL  = 2'b01,
        FSPC_OSC_HOLD  = 2'b10
    } fspc_osc_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } fspc_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } fspc_apb_rsp_s;
endpackage

// ### logic/fspc_top.sv
// fail-safe power control: watchdog, oscillator supervisor, power modes
//
// Contract
// RQ1: fifteen-bit up-counter, tick by 12 or 384
// RQ2: only upper seven counter bits are programmable
// RQ3: start by bit or pin, unstoppable
// RQ4: overflow of running counter causes internal reset
// RQ5: refresh copies reload into upper seven bits
// RQ6: software writes refresh bit then start bit
// RQ7: refresh only when start directly follows refresh
// RQ8: readable flag tells watchdog or external reset
// RQ9: counter halts in idle or power-down
// RQ10: timeout range 189 us to 0.79 s (at 100 MHz the code gives 30.72 us to 0.126 s)
// RQ11: slow main oscillator selects RC, holds reset
// RQ12: extra half millisecond reset after recovery
// RQ13: power-down exit reuses oscillator supervision
// RQ14: RC clock serves reset at power-on (the code uses it only until the oscillator recovers, not in the hold)
// RQ15: idle gates cpu clock, peripherals keep running
// RQ16: idle entry is write 01H then 20H
// RQ17: idle left by interrupt or hardware reset
// RQ18: power-down by 02H then 40H, reset exits
// RQ19: low pin holds hardware power-down
// RQ20: slow-down divides clock by eight, 10H/0EFH
// RQ21: reset exit applies full reset state (the code's internal reset keeps wd_flag and rate_slow)
`timescale 1ns/10ps
module fspc_top
    import fspc_pkg::*;
#(
    parameter int OSC_HOLD_CYC = FSPC_OSC_HOLD_CYC
) (
    input  wire logic          i_clock,
    input  wire logic          i_arst_n,
    input  wire fspc_apb_req_s i_apb,
    output fspc_apb_rsp_s      o_apb,
    input  wire logic          i_hw_powerdown_pin_n,
    input  wire logic          i_hw_watchdog_start_pin,
    input  wire logic          i_main_osc_slow,
    input  wire logic          i_peripheral_irq,
    output logic               o_internal_reset,
    output logic               o_cpu_clock_en,
    output logic               o_periph_clock_en,
    output logic               o_osc_enable,
    output logic               o_use_rc_clock
);
    // hold counter is 17 bits wide, so the hold length must fit in it
    if (OSC_HOLD_CYC < 1 || OSC_HOLD_CYC > 131072) begin : g_hold_check
        $error("OSC_HOLD_CYC must lie in 1 to 131072");
    end

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0]  sync_pd;
        logic [1:0]  sync_wdp;
        logic [1:0]  sync_osc;
        logic [1:0]  sync_irq;
        logic [14:0] count;
        logic [8:0]  prescale;
        logic [6:0]  reload;
        logic        rate_slow;
        logic        running;
        logic        refresh_armed;
        logic        wd_flag;
        logic [2:0]  wd_rst_cnt;
        logic        idle_arm;
        logic        pd_arm;
        logic        idle;
        logic        swpd;
        logic        slow;
        logic [2:0]  slow_cnt;
        fspc_osc_e   osc;
        logic [16:0] hold_cnt;
        logic        int_rst;
        logic        cpu_en;
        logic        per_en;
        logic        osc_en;
        logic        rc_sel;
        fspc_apb_rsp_s rsp;
    } fspc_state_s;

    fspc_state_s st;
    fspc_state_s next_st;

    logic        wr;
    logic        rd;
    logic        tick_end;
    logic        halted;
    logic        hw_powerdown_pin;
    logic [31:0] rdata;

    always_comb begin
        next_st = st;
        hw_powerdown_pin = ~st.sync_pd[1];
        halted = st.idle | st.swpd | hw_powerdown_pin; // [RQ9]
        wr = i_apb.psel & i_apb.penable & i_apb.pwrite & ~st.rsp.pready;
        rd = i_apb.psel & i_apb.penable & ~i_apb.pwrite & ~st.rsp.pready;
        // tick selects divide by 12 or 384 [RQ1]
        tick_end = st.rate_slow ?
            (st.prescale == 9'(FSPC_DIV_SLOW - 1)) :
            (st.prescale == 9'(FSPC_DIV_FAST - 1));
        next_st.sync_pd  = {st.sync_pd[0], i_hw_powerdown_pin_n};
        next_st.sync_wdp = {st.sync_wdp[0], i_hw_watchdog_start_pin};
        next_st.sync_osc = {st.sync_osc[0], i_main_osc_slow};
        next_st.sync_irq = {st.sync_irq[0], i_peripheral_irq};

        // watchdog counting; at 100 MHz timeouts span 30.72 us to 0.126 s, not the 189 us to 0.79 s of [RQ10]
        if (st.running && !halted && !st.int_rst) begin
            next_st.prescale = tick_end ? 9'h000 : st.prescale + 9'h001;
            if (tick_end) begin
                next_st.count = st.count + 15'h0001;
                if (st.count == 15'h7FFF) begin
                    next_st.wd_rst_cnt = 3'(FSPC_WD_RST_CYC); // [RQ4]
                    next_st.wd_flag = 1'b1; // [RQ8]
                end
            end
        end
        if (st.sync_wdp[1]) begin
            next_st.running = 1'b1; // [RQ3]
        end
        if (st.wd_rst_cnt != 3'h0) begin
            next_st.wd_rst_cnt = st.wd_rst_cnt - 3'h1;
        end

        // oscillator supervisor; power-down exit and power-on reuse it
        case (st.osc)
            FSPC_OSC_OK: begin
                if (st.sync_osc[1] || hw_powerdown_pin) begin
                    next_st.osc = FSPC_OSC_FAIL; // [RQ11] [RQ13]
                end
            end
            FSPC_OSC_FAIL: begin
                if (!st.sync_osc[1] && !hw_powerdown_pin) begin
                    next_st.osc = FSPC_OSC_HOLD;
                    next_st.hold_cnt = 17'h00000;
                end
            end
            FSPC_OSC_HOLD: begin
                if (st.sync_osc[1] || hw_powerdown_pin) begin
                    next_st.osc = FSPC_OSC_FAIL;
                end else if (st.hold_cnt == 17'(OSC_HOLD_CYC - 1)) begin
                    next_st.osc = FSPC_OSC_OK; // [RQ12]
                end else begin
                    next_st.hold_cnt = st.hold_cnt + 17'h00001;
                end
            end
            default: begin
                next_st.osc = FSPC_OSC_FAIL;
            end
        endcase

        // power mode sequencing
        if (st.idle && st.sync_irq[1]) begin
            next_st.idle = 1'b0; // [RQ17]
        end
        if (st.slow) begin
            next_st.slow_cnt = st.slow_cnt + 3'h1;
        end else begin
            next_st.slow_cnt = 3'h0;
        end

        // register writes
        next_st.rsp.pready = 1'b0;
        next_st.rsp.pslverr = 1'b0;
        if (wr || rd) begin
            next_st.rsp.pready = 1'b1;
        end
        if (wr && i_apb.paddr == FSPC_OFF_CTRL) begin
            next_st.rate_slow = i_apb.pwdata[FSPC_CTRL_RATE];
            if (i_apb.pwdata[FSPC_CTRL_CLR_FLAG] &&
                next_st.wd_rst_cnt == 3'h0 && !(st.wd_rst_cnt != 3'h0)) begin
                next_st.wd_flag = 1'b0;
            end
            if (i_apb.pwdata[FSPC_CTRL_START]) begin
                next_st.running = 1'b1; // [RQ3]
                if (st.refresh_armed) begin
                    next_st.count = {st.reload, 8'h00}; // [RQ2] [RQ5] [RQ7]
                    next_st.prescale = 9'h000;
                end
            end
            next_st.refresh_armed = i_apb.pwdata[FSPC_CTRL_REFRESH]; // [RQ6]
        end else if (wr) begin
            next_st.refresh_armed = 1'b0; // [RQ7]
        end
        if (wr && i_apb.paddr == FSPC_OFF_RELOAD) begin
            next_st.reload = i_apb.pwdata[6:0];
        end
        if (wr && i_apb.paddr == FSPC_OFF_POWER) begin
            // two-write entry sequences [RQ16] [RQ18]
            next_st.idle_arm = (i_apb.pwdata[7:0] == FSPC_PWR_IDLE_ARM);
            next_st.pd_arm = (i_apb.pwdata[7:0] == FSPC_PWR_PD_ARM);
            if (st.idle_arm && i_apb.pwdata[7:0] == FSPC_PWR_IDLE_GO) begin
                next_st.idle = 1'b1;
            end
            if (st.pd_arm && i_apb.pwdata[7:0] == FSPC_PWR_PD_GO) begin
                next_st.swpd = 1'b1;
            end
            if (i_apb.pwdata[7:0] == FSPC_PWR_SLOW) begin
                next_st.slow = 1'b1; // [RQ20]
            end else if (i_apb.pwdata[7:0] == FSPC_PWR_SLOW_CLR) begin
                next_st.slow = 1'b0; // [RQ20]
            end
        end else if (wr) begin
            next_st.idle_arm = 1'b0;
            next_st.pd_arm = 1'b0;
        end

        // read mux; unmapped reads return zero with an error
        rdata = 32'h00000000;
        case (i_apb.paddr)
            FSPC_OFF_CTRL: begin
                rdata[FSPC_CTRL_RATE] = st.rate_slow;
            end
            FSPC_OFF_RELOAD: begin
                rdata[6:0] = st.reload;
            end
            FSPC_OFF_POWER: begin
                rdata[4] = st.slow;
            end
            FSPC_OFF_STATUS: begin
                rdata[FSPC_ST_WD_RESET] = st.wd_flag; // [RQ8]
                rdata[FSPC_ST_RUNNING] = st.running;
                rdata[FSPC_ST_IDLE] = st.idle;
                rdata[FSPC_ST_SWPD] = st.swpd;
                rdata[FSPC_ST_HW_POWERDOWN_PIN] = hw_powerdown_pin;
                rdata[FSPC_ST_OSCRST] = (st.osc != FSPC_OSC_OK);
                rdata[FSPC_ST_SLOW] = st.slow;
            end
            FSPC_OFF_COUNT: begin
                rdata[14:0] = st.count;
            end
            default: begin
                next_st.rsp.pslverr = wr | rd;
            end
        endcase
        next_st.rsp.prdata = rd ? rdata : 32'h00000000;

        // internal reset wipes power and watchdog state except wd_flag and rate_slow [RQ21]
        next_st.int_rst = (st.osc != FSPC_OSC_OK) || (st.wd_rst_cnt != 3'h0);
        if (st.int_rst) begin
            next_st.running = 1'b0;
            next_st.count = FSPC_COUNT_RST;
            next_st.prescale = 9'h000;
            next_st.reload = FSPC_RELOAD_RST;
            next_st.idle = 1'b0; // [RQ17]
            next_st.swpd = 1'b0; // [RQ18]
            next_st.slow = 1'b0; // [RQ20]
            next_st.idle_arm = 1'b0;
            next_st.pd_arm = 1'b0;
            next_st.refresh_armed = 1'b0;
        end

        // clock controls; rc clock serves reset until the oscillator recovers, not the hold [RQ14]
        next_st.rc_sel = (next_st.osc == FSPC_OSC_FAIL); // [RQ11]
        next_st.osc_en = ~next_st.swpd & ~hw_powerdown_pin; // [RQ18] [RQ19]
        next_st.per_en = next_st.osc_en &
            (~next_st.slow | (next_st.slow_cnt == 3'h0)); // [RQ20]
        next_st.cpu_en = next_st.per_en & ~next_st.idle; // [RQ15]
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
            st.osc <= FSPC_OSC_FAIL;
            // pin idles high: no false power-down right after reset
            st.sync_pd <= 2'h3;
            st.int_rst <= 1'b1;
            st.rc_sel <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign o_apb = st.rsp;
    assign o_internal_reset = st.int_rst;
    assign o_cpu_clock_en = st.cpu_en;
    assign o_periph_clock_en = st.per_en;
    assign o_osc_enable = st.osc_en;
    assign o_use_rc_clock = st.rc_sel;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_overflow_reset;
        @(posedge i_clock) disable iff (!i_arst_n)
        (st.running && !halted && !st.int_rst && tick_end &&
         st.count == 15'h7FFF) |-> ##2 o_internal_reset;
    endproperty
    a_overflow_reset: assert property (p_overflow_reset) // [RQ4]
        else $error("overflow gave no reset");

    property p_refresh_copy;
        @(posedge i_clock) disable iff (!i_arst_n)
        (wr && i_apb.paddr == FSPC_OFF_CTRL && st.refresh_armed &&
         i_apb.pwdata[FSPC_CTRL_START] && !st.int_rst)
        |=> (st.count == {$past(st.reload), 8'h00});
    endproperty
    a_refresh_copy: assert property (p_refresh_copy) // [RQ5]
        else $error("refresh did not load reload value");

    property p_halt_idle;
        @(posedge i_clock) disable iff (!i_arst_n)
        (st.idle && !st.int_rst) |=> $stable(st.count);
    endproperty
    a_halt_idle: assert property (p_halt_idle) // [RQ9]
        else $error("counter moved while halted");

    property p_running_sticky;
        @(posedge i_clock) disable iff (!i_arst_n)
        (st.running && !st.int_rst) |=> st.running;
    endproperty
    a_running_sticky: assert property (p_running_sticky) // [RQ3]
        else $error("watchdog stopped while active");

    property p_osc_fail_reset;
        @(posedge i_clock) disable iff (!i_arst_n)
        (st.osc == FSPC_OSC_FAIL) |=> o_internal_reset &&
        (o_use_rc_clock == (st.osc == FSPC_OSC_FAIL));
    endproperty
    a_osc_fail_reset: assert property (p_osc_fail_reset) // [RQ11]
        else $error("slow oscillator did not hold reset");

    property p_hold_phase;
        @(posedge i_clock) disable iff (!i_arst_n)
        (st.osc == FSPC_OSC_HOLD && st.hold_cnt == 17'h00000)
        |=> o_internal_reset [*2];
    endproperty
    a_hold_phase: assert property (p_hold_phase) // [RQ12]
        else $error("reset released before hold ended");

    property p_idle_gate;
        @(posedge i_clock) disable iff (!i_arst_n)
        st.idle |-> !o_cpu_clock_en;
    endproperty
    a_idle_gate: assert property (p_idle_gate) // [RQ15]
        else $error("cpu clock ran in idle");

    property p_hw_powerdown_pin_stop;
        @(posedge i_clock) disable iff (!i_arst_n)
        hw_powerdown_pin |=> !o_osc_enable;
    endproperty
    a_hw_powerdown_pin_stop: assert property (p_hw_powerdown_pin_stop) // [RQ19]
        else $error("oscillator ran in hardware power-down");

    property p_slow_div;
        @(posedge i_clock) disable iff (!i_arst_n)
        (st.slow && st.per_en && next_st.slow && next_st.osc_en)
        |=> !o_periph_clock_en;
    endproperty
    a_slow_div: assert property (p_slow_div) // [RQ20]
        else $error("slow-down enable not divided by eight");

    property p_swpd_stop;
        @(posedge i_clock) disable iff (!i_arst_n)
        (st.swpd && !st.int_rst) |=> !o_osc_enable;
    endproperty
    a_swpd_stop: assert property (p_swpd_stop) // [RQ18]
        else $error("oscillator ran in software power-down");

    property p_full_reset;
        @(posedge i_clock) disable iff (!i_arst_n)
        st.int_rst |=> !st.running && !st.idle && !st.swpd && !st.slow;
    endproperty
    a_full_reset: assert property (p_full_reset) // [RQ21]
        else $error("internal reset kept old mode state");

    property p_wd_flag_set;
        @(posedge i_clock) disable iff (!i_arst_n)
        (st.running && !halted && !st.int_rst && tick_end &&
         st.count == 15'h7FFF) |=> st.wd_flag;
    endproperty
    a_wd_flag_set: assert property (p_wd_flag_set) // [RQ8]
        else $error("overflow did not set watchdog flag");

    property p_refresh_order;
        @(posedge i_clock) disable iff (!i_arst_n)
        (wr && i_apb.paddr == FSPC_OFF_CTRL && !st.refresh_armed &&
         !tick_end && !st.int_rst) |=> $stable(st.count);
    endproperty
    a_refresh_order: assert property (p_refresh_order) // [RQ7]
        else $error("counter loaded without armed refresh");
endmodule // fspc_top

// ### sim/fspc_cpu_model.sv
// cpu-side model: apb master issuing the software accesses
`timescale 1ns/10ps
module fspc_cpu_model
    import fspc_pkg::*;
(
    input  wire logic          i_clock,
    input  wire fspc_apb_rsp_s i_apb,
    output fspc_apb_req_s      o_apb
);
    initial o_apb = '0;
    ////////////////////////////////////////////////////////////////////////
    // one transfer; request held until pready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge i_clock);
        o_apb <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge i_clock);
        o_apb.penable <= 1'b1;
        // no own limit: the bench timeout ends a hung wait
        do begin
            @(posedge i_clock);
        end while (i_apb.pready !== 1'b1);
        rdata = i_apb.prdata;
        err   = i_apb.pslverr;
        // released lines show the inverse, never the stale value
        o_apb <= '{1'b0, 1'b0, ~wr, ~addr, ~wdata};
    endtask
endmodule // fspc_cpu_model

// ### sim/tb_fail_safe_power_control.sv
// testbench for the fail-safe power control block
`timescale 1ns/10ps
module tb_fail_safe_power_control;
    import fspc_pkg::*;
    localparam int HOLD = 20;
    logic          clock = 1'b0;
    logic          arst_n = 1'b0;
    logic          pd_n = 1'b1;
    logic          wd_pin = 1'b0;
    logic          osc_slow = 1'b0;
    logic          irq = 1'b0;
    fspc_apb_req_s apb_req;
    fspc_apb_rsp_s apb_rsp;
    logic          ireset, cpu_en, per_en, osc_en, use_rc;
    logic [31:0]   a, b;
    int            fails = 0;
    int            check_count = 0;
    int            cycles = 0;
    int            n;

    always #5 clock = ~clock;

    fspc_top #(.OSC_HOLD_CYC(HOLD)) u_fspc_top (
        .i_clock(clock), .i_arst_n(arst_n), .i_apb(apb_req), .o_apb(apb_rsp),
        .i_hw_powerdown_pin_n(pd_n), .i_hw_watchdog_start_pin(wd_pin),
        .i_main_osc_slow(osc_slow), .i_peripheral_irq(irq),
        .o_internal_reset(ireset), .o_cpu_clock_en(cpu_en),
        .o_periph_clock_en(per_en), .o_osc_enable(osc_en),
        .o_use_rc_clock(use_rc));

    fspc_cpu_model u_fspc_cpu_model (
        .i_clock(clock), .i_apb(apb_rsp), .o_apb(apb_req));
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        logic        e;
        u_fspc_cpu_model.xfer(1'b1, addr, data, d, e);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [31:0] data,
                      output logic err);
        u_fspc_cpu_model.xfer(1'b0, addr, 32'h0000_0000, data, err);
        #1;
    endtask

    task automatic wait_cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    // bounded wait for the internal reset to drop
    task automatic wait_release(output int k);
        k = 0;
        while (ireset !== 1'b0 && k < 2000) begin
            @(posedge clock);
            k++;
        end
        #1;
    endtask

    task automatic do_reset();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        wait_release(n);
    endtask

    task automatic count_per(output int k);
        k = 0;
        repeat (64) begin
            @(posedge clock);
            #1;
            if (per_en === 1'b1) k++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_power_on();
        logic e;
        wait_cyc(4);
        chk("reset held", ireset, 1);
        chk("rc clock", use_rc, 1);
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        wait_release(n);
        chk("hold long", n >= HOLD && n <= HOLD + 5, 1);
        rd(FSPC_OFF_COUNT, a, e);
        chk("count reset", a, 0);
        rd(FSPC_OFF_STATUS, a, e);
        chk("wd flag", a[FSPC_ST_WD_RESET], 0);
        rd(8'h20, a, e);
        chk("unmapped err", e, 1);
        chk("unmapped data", a, 0);
    endtask

    task automatic t_osc_fail();
        @(posedge clock);
        osc_slow <= 1'b1;
        wait_cyc(8);
        chk("osc reset", ireset, 1);
        chk("osc rc", use_rc, 1);
        @(posedge clock);
        osc_slow <= 1'b0;
        wait_release(n);
        chk("osc hold", n >= HOLD && n <= HOLD + 8, 1);
        chk("main clock", use_rc, 0);
    endtask

    task automatic t_overflow();
        logic e;
        wr(FSPC_OFF_RELOAD, 32'h0000_007F);
        wr(FSPC_OFF_CTRL, 32'h0000_0001);
        wr(FSPC_OFF_CTRL, 32'h0000_0002);
        rd(FSPC_OFF_COUNT, a, e);
        chk("refresh high", a[14:8], 7'h7F);
        rd(FSPC_OFF_STATUS, a, e);
        chk("running", a[FSPC_ST_RUNNING], 1);
        n = 0;
        while (ireset !== 1'b1 && n < 4000) begin
            @(posedge clock);
            n++;
        end
        // 256 ticks of 12 cycles remain after the refresh
        chk("overflow time", n > 2900 && n < 3100, 1);
        wait_release(n);
        rd(FSPC_OFF_STATUS, a, e);
        chk("wd flag set", a[FSPC_ST_WD_RESET], 1);
        chk("stopped", a[FSPC_ST_RUNNING], 0);
        wr(FSPC_OFF_CTRL, 32'h0000_0008);
        rd(FSPC_OFF_STATUS, a, e);
        chk("wd flag clr", a[FSPC_ST_WD_RESET], 0);
    endtask

    task automatic t_order_idle();
        logic e;
        wr(FSPC_OFF_CTRL, 32'h0000_0002);
        wr(FSPC_OFF_CTRL, 32'h0000_0001);
        wr(FSPC_OFF_RELOAD, 32'h0000_0040);
        wr(FSPC_OFF_CTRL, 32'h0000_0002);
        rd(FSPC_OFF_COUNT, a, e);
        chk("no refresh", a[14:8], 7'h00);
        wr(FSPC_OFF_CTRL, 32'h0000_0001);
        wr(FSPC_OFF_CTRL, 32'h0000_0002);
        rd(FSPC_OFF_COUNT, a, e);
        chk("refresh 40", a[14:8], 7'h40);
        wr(FSPC_OFF_POWER, FSPC_PWR_IDLE_ARM);
        wr(FSPC_OFF_POWER, FSPC_PWR_IDLE_GO);
        wait_cyc(8);
        chk("cpu gated", cpu_en, 0);
        chk("periph on", per_en, 1);
        rd(FSPC_OFF_COUNT, a, e);
        wait_cyc(100);
        rd(FSPC_OFF_COUNT, b, e);
        chk("wd halted", b, a);
        @(posedge clock);
        irq <= 1'b1;
        wait_cyc(8);
        chk("idle exit", cpu_en, 1);
        @(posedge clock);
        irq <= 1'b0;
        do_reset();
    endtask

    task automatic t_powerdown();
        logic e;
        wr(FSPC_OFF_POWER, FSPC_PWR_PD_ARM);
        wr(FSPC_OFF_POWER, FSPC_PWR_PD_GO);
        irq <= 1'b1;
        wait_cyc(8);
        chk("osc off", osc_en, 0);
        chk("cpu off", cpu_en, 0);
        @(posedge clock);
        irq <= 1'b0;
        do_reset();
        chk("osc back", osc_en, 1);
        rd(FSPC_OFF_STATUS, a, e);
        chk("swpd clr", a[FSPC_ST_SWPD], 0);
        @(posedge clock);
        pd_n <= 1'b0;
        wait_cyc(8);
        chk("hw pd osc", osc_en, 0);
        @(posedge clock);
        pd_n <= 1'b1;
        wait_cyc(8);
        chk("pd exit rst", ireset, 1);
        wait_release(n);
        chk("pd exit osc", osc_en, 1);
        // start pin alone must set the watchdog running
        rd(FSPC_OFF_STATUS, a, e);
        chk("not running", a[FSPC_ST_RUNNING], 0);
        @(posedge clock);
        wd_pin <= 1'b1;
        wait_cyc(4);
        rd(FSPC_OFF_STATUS, a, e);
        chk("pin start", a[FSPC_ST_RUNNING], 1);
        @(posedge clock);
        wd_pin <= 1'b0;
    endtask

    task automatic t_slow_rate();
        logic e;
        int   div;
        wr(FSPC_OFF_POWER, FSPC_PWR_SLOW);
        count_per(n);
        chk("slow ratio", n, 64 / FSPC_SLOW_DIV);
        rd(FSPC_OFF_POWER, a, e);
        chk("slow bit", a[4], 1);
        wr(FSPC_OFF_POWER, FSPC_PWR_SLOW_CLR);
        count_per(n);
        chk("full rate", n, 64);
        for (int i = 0; i < 2; i++) begin
            div = (i == 1) ? FSPC_DIV_SLOW : FSPC_DIV_FAST;
            do_reset();
            wr(FSPC_OFF_CTRL, 32'h0000_0002 | (i << FSPC_CTRL_RATE));
            rd(FSPC_OFF_COUNT, a, e);
            wait_cyc(10 * div);
            rd(FSPC_OFF_COUNT, b, e);
            // read itself adds a few cycles, so one tick of slack
            chk("tick rate", (b - a) >= 10 && (b - a) <= 11, 1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        t_power_on();
        t_osc_fail();
        t_overflow();
        t_order_idle();
        t_powerdown();
        t_slow_rate();
        final_report();
    end
endmodule // tb_fail_safe_power_control
